// >>> hw/qdac_pkg.sv
/*
 * shared constants and types of the quad converter two-wire control block.
 * assumes a 20 MHz hclk; every other rate is derived from it.
 */
package qdac_pkg;

   localparam int NCH = 4;
   localparam int CODE_W = 12;

   // fixed upper slave address bits, pin gives the lowest
   localparam logic [5:0] ADDR_HI = 6'h06;

   // readback word when no single channel is selected
   localparam logic [15:0] RB_DEFAULT = 16'h2000;
   // control after reset: clear_ctl_n high, load_ctl_n low
   localparam logic [1:0] CTL_RST = 2'h2;
   localparam logic CTRL_EN_RST = 1'h1;

   // positions inside the most significant data byte
   localparam int HB_PD_HI = 7;
   localparam int HB_PD_LO = 6;
   localparam int HB_CLR = 5;
   localparam int HB_LOAD_CTL_N = 4;

   // power-down modes
   localparam logic [1:0] PD_NORMAL = 2'h0;
   localparam logic [1:0] PD_GND_1K = 2'h1;
   localparam logic [1:0] PD_GND_100K = 2'h2;
   localparam logic [1:0] PD_OPEN = 2'h3;

   // byte positions within one transfer
   localparam logic [2:0] BY_ADDR = 3'h0;
   localparam logic [2:0] BY_PTR = 3'h1;
   localparam logic [2:0] BY_HI = 3'h2;
   localparam logic [2:0] BY_LO = 3'h3;
   localparam logic [2:0] BY_EXTRA = 3'h4;

   // power-down exit time and its cycle count, rounded up
   localparam real CLK_MHZ = 20.0;
   localparam real PD_EXIT_US = 2.5;
   localparam logic [5:0] PD_EXIT_CYC =
      6'(int'($ceil(PD_EXIT_US * CLK_MHZ)));

   // bus register byte offsets
   localparam logic [7:0] OFF_CODE0 = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_CTRL = 8'h14;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RXB, ST_ACKW, ST_ACKD, ST_TXB, ST_TXE, ST_MACK, ST_TXN
   } qdac_st_e;

endpackage

// >>> hw/qdac_ev_if.sv
/*
 * bus events passed from the pin synchroniser to the control core.
 * assumes both ends run on hclk; every signal is a one-cycle pulse or level.
 */
`timescale 1ns/1ps
interface qdac_ev_if;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   logic sda;
   logic a0;
   modport src (output scl_rise, scl_fall, start, stop, sda, a0);
   modport dst (input scl_rise, scl_fall, start, stop, sda, a0);
endinterface

// >>> hw/qdac_pinsync.sv
/*
 * two-flop synchronisers for the serial pins and the address strap,
 * with clock edge and start/stop detection.
 * assumes the pins are asynchronous to hclk and far slower than it.
 */
`timescale 1ns/1ps
module qdac_pinsync
   import qdac_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic a0_in,
   qdac_ev_if.src evo
);

   typedef struct packed {
      logic scl_m, scl_s, scl_p;
      logic sda_m, sda_s, sda_p;
      logic a0_m, a0_s;
   } qdac_sync_s;

   qdac_sync_s s_q, s_d;

   // shift the pins through two stages, keep one more for edges
   always_comb begin
      s_d = s_q;
      s_d.scl_m = scl_in;
      s_d.scl_s = s_q.scl_m;
      s_d.scl_p = s_q.scl_s;
      s_d.sda_m = sda_in;
      s_d.sda_s = s_q.sda_m;
      s_d.sda_p = s_q.sda_s;
      s_d.a0_m = a0_in;
      s_d.a0_s = s_q.a0_m;
   end

   // idle bus levels are high
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   // events seen only from settled stages
   assign evo.scl_rise = s_q.scl_s & ~s_q.scl_p;
   assign evo.scl_fall = ~s_q.scl_s & s_q.scl_p;
   assign evo.start = s_q.scl_s & s_q.scl_p & s_q.sda_p & ~s_q.sda_s;
   assign evo.stop = s_q.scl_s & s_q.scl_p & ~s_q.sda_p & s_q.sda_s;
   assign evo.sda = s_q.sda_s;
   assign evo.a0 = s_q.a0_s;

endmodule

// >>> hw/qdac_ctrl.sv
/*
 * digital control of a quad voltage-output converter on a two-wire bus:
 * slave receiver/transmitter, double-buffered code registers, clear,
 * power-down mode control and an AHB-Lite register window.
 * assumes hclk at 20 MHz, far faster than the serial clock.
 */
`timescale 1ns/1ps
module qdac_ctrl
   import qdac_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_select_pin,
   output logic [3:0][11:0] dac_code,
   output logic [1:0] pwrdn_mode,
   output logic out_amp_on,
   output logic out_gnd_1k,
   output logic out_gnd_100k,
   output logic out_open
);

   typedef struct packed {
      qdac_st_e st;
      logic [2:0] cnt;
      logic [2:0] idx;
      logic [7:0] sh;
      logic [7:0] hi;
      logic rw;
      logic [3:0] ptr;
      logic wr_done;
      logic txlo;
      logic oe;
      logic [3:0][11:0] inp;
      logic [3:0][11:0] dac;
      logic [3:0] chg;
      logic [1:0] pd;
      logic [1:0] ctl;
      logic [5:0] rec;
      logic amp_on, gnd_1k, gnd_100k, open_o;
      logic en;
      logic a_wr;
      logic [2:0] a_idx;
      logic [31:0] rdata;
      logic rdy;
   } qdac_core_s;

   qdac_core_s s_q, n;
   qdac_ev_if ev();

   qdac_pinsync u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .a0_in(addr_select_pin),
      .evo(ev)
   );

   // register word seen by a bus read
   function automatic logic [31:0] rd_word(qdac_core_s s, logic [2:0] i);
      logic [31:0] w;
      w = 32'h0;
      if (i < OFF_STATUS[4:2]) begin
         w = {20'h0, s.dac[i[1:0]]};
      end else if (i == OFF_STATUS[4:2]) begin
         w = {20'h0, s.ptr, s.chg, s.pd, s.ctl};
      end else if (i == OFF_CTRL[4:2]) begin
         w = {31'h0, s.en};
      end
      return w;
   endfunction

   // next state of bus slave, serial engine and code registers
   always_comb begin
      logic [7:0] b;
      logic [11:0] code;
      logic [15:0] rb;
      logic [1:0] sel;
      logic single;
      n = s_q;
      b = {s_q.sh[6:0], ev.sda};
      code = {s_q.hi[3:0], s_q.sh};
      sel = 2'h0;
      for (int i = 0; i < NCH; i++) begin
         if (s_q.ptr[i]) begin
            sel = 2'(i);
         end
      end
      single = (s_q.ptr != 4'h0) && ((s_q.ptr & (s_q.ptr - 4'h1)) == 4'h0);
      rb = single ? {s_q.pd, s_q.ctl, s_q.inp[sel]} : RB_DEFAULT;

      // bus slave: capture address phase, act in data phase
      n.rdy = 1'b1;
      n.a_wr = 1'b0;
      if (s_q.a_wr && s_q.a_idx == OFF_CTRL[4:2]) begin
         n.en = hwdata[0];
      end
      if (hsel && htrans[1] && hready && hsize == HSIZE_WORD) begin
         n.a_wr = hwrite && (haddr[31:5] == 27'h0);
         n.a_idx = haddr[4:2];
         if (!hwrite) begin
            n.rdata = (haddr[31:5] == 27'h0) ? rd_word(s_q, haddr[4:2])
                                              : 32'h0;
         end
      end

      if (ev.start) begin
         n.st = ST_RXB;
         n.cnt = 3'h0;
         n.idx = BY_ADDR;
         n.wr_done = 1'b0;
         n.oe = 1'b0;
      end else if (ev.stop) begin
         if (s_q.wr_done) begin
            n.ctl = {s_q.hi[HB_CLR], s_q.hi[HB_LOAD_CTL_N]};
            if (!s_q.hi[HB_CLR]) begin
               n.inp = '0;
               n.dac = '0;
               n.chg = 4'h0;
            end else begin
               for (int i = 0; i < NCH; i++) begin
                  if (s_q.ptr[i]) begin
                     n.inp[i] = code;
                     n.chg[i] = 1'b1;
                  end
               end
               if (!s_q.hi[HB_LOAD_CTL_N]) begin
                  for (int i = 0; i < NCH; i++) begin
                     if (n.chg[i]) begin
                        n.dac[i] = n.inp[i];
                     end
                  end
                  n.chg = 4'h0;
               end
            end
         end
         n.st = ST_IDLE;
         n.wr_done = 1'b0;
         n.oe = 1'b0;
      end else begin
         case (s_q.st)
            ST_RXB: begin
               if (ev.scl_rise) begin
                  // low data byte held for the stop once both are in
                  n.sh = (s_q.idx == BY_EXTRA) ? s_q.sh : b;
                  n.cnt = s_q.cnt + 3'h1;
                  if (s_q.cnt == 3'h7) begin
                     n.st = ST_ACKW;
                     if (s_q.idx != BY_EXTRA) begin
                        n.idx = s_q.idx + 3'h1;
                     end
                     case (s_q.idx)
                        BY_ADDR: begin
                           if (!s_q.en || b[7:1] != {ADDR_HI, ev.a0}) begin
                              n.st = ST_IDLE;
                           end
                           n.rw = b[0];
                        end
                        BY_PTR: n.ptr = b[3:0];
                        BY_HI: begin
                           n.hi = b;
                           n.pd = b[HB_PD_HI:HB_PD_LO];
                        end
                        BY_LO: n.wr_done = 1'b1;
                        // no more than two data bytes
                        default: n.st = ST_IDLE;
                     endcase
                  end
               end
            end
            ST_ACKW: begin
               if (ev.scl_fall) begin
                  n.oe = 1'b1;
                  n.st = ST_ACKD;
               end
            end
            ST_ACKD: begin
               if (ev.scl_fall) begin
                  n.cnt = 3'h0;
                  if (s_q.rw) begin
                     n.sh = rb[15:8];
                     n.oe = ~rb[15];
                     n.txlo = 1'b1;
                     n.st = ST_TXB;
                  end else begin
                     n.oe = 1'b0;
                     n.st = ST_RXB;
                  end
               end
            end
            ST_TXB: begin
               if (ev.scl_fall) begin
                  n.sh = {s_q.sh[6:0], 1'b0};
                  n.oe = ~s_q.sh[6];
               end else if (ev.scl_rise) begin
                  n.cnt = s_q.cnt + 3'h1;
                  if (s_q.cnt == 3'h7) begin
                     n.st = ST_TXE;
                  end
               end
            end
            ST_TXE: begin
               if (ev.scl_fall) begin
                  n.oe = 1'b0;
                  n.st = ST_MACK;
               end
            end
            ST_MACK: begin
               if (ev.scl_rise) begin
                  n.st = ev.sda ? ST_IDLE : ST_TXN;
               end
            end
            ST_TXN: begin
               if (ev.scl_fall) begin
                  n.sh = s_q.txlo ? rb[7:0] : rb[15:8];
                  n.oe = s_q.txlo ? ~rb[7] : ~rb[15];
                  n.txlo = ~s_q.txlo;
                  n.cnt = 3'h0;
                  n.st = ST_TXB;
               end
            end
            default: ;
         endcase
      end

      if (s_q.pd != PD_NORMAL && n.pd == PD_NORMAL) begin
         n.rec = PD_EXIT_CYC;
      end else if (s_q.rec != 6'h0) begin
         n.rec = s_q.rec - 6'h1;
      end
      n.amp_on = (n.pd == PD_NORMAL) && (n.rec == 6'h0);
      n.gnd_1k = n.pd == PD_GND_1K;
      n.gnd_100k = n.pd == PD_GND_100K;
      n.open_o = n.pd == PD_OPEN;
   end

   // state register, constants only at reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
         s_q.ctl <= CTL_RST;
         s_q.en <= CTRL_EN_RST;
         s_q.amp_on <= 1'b1;
         s_q.rdy <= 1'b1;
      end else begin
         s_q <= n;
      end
   end

   // outputs straight from the state register, hresp and sda_out tied low
   assign hreadyout = s_q.rdy;
   assign hrdata = s_q.rdata;
   assign hresp = 1'b0;
   assign sda_out = 1'b0;
   assign sda_oe = s_q.oe;
   assign dac_code = s_q.dac;
   assign pwrdn_mode = s_q.pd;
   assign out_amp_on = s_q.amp_on;
   assign out_gnd_1k = s_q.gnd_1k;
   assign out_gnd_100k = s_q.gnd_100k;
   assign out_open = s_q.open_o;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // checks of the serial engine, the code registers and the power-down outputs
   a_multi_default: assert property (s_q.st == ST_ACKD && ev.scl_fall
      && s_q.rw && ((s_q.ptr & (s_q.ptr - 4'h1)) != 4'h0)
      |=> s_q.sh == RB_DEFAULT[15:8])
      else $error("multi-channel readback not default");
   a_pd_field: assert property (s_q.st == ST_RXB && ev.scl_rise
      && s_q.cnt == 3'h7 && s_q.idx == BY_HI && !ev.start && !ev.stop
      |=> s_q.pd == $past(s_q.sh[6:5]))
      else $error("power-down mode not taken from bits 15:14");
   a_ack_drive: assert property (s_q.st == ST_ACKW && ev.scl_fall
      && !ev.start && !ev.stop |=> sda_oe ##1 sda_oe[*1])
      else $error("acknowledge not driven");
   a_foreign_addr: assert property (s_q.st == ST_RXB && ev.scl_rise
      && s_q.cnt == 3'h7 && s_q.idx == BY_ADDR && !ev.start && !ev.stop
      && s_q.sh[6:0] != {ADDR_HI, ev.a0} |=> s_q.st == ST_IDLE
      && !sda_oe)
      else $error("foreign address answered");
   a_load_ctl_n_hold: assert property (ev.stop && !ev.start && s_q.wr_done
      && s_q.hi[HB_CLR] && s_q.hi[HB_LOAD_CTL_N] |=> $stable(s_q.dac))
      else $error("converter changed with load held");
   a_clear_zero: assert property (ev.stop && !ev.start && s_q.wr_done
      && !s_q.hi[HB_CLR] |=> s_q.dac == '0 && s_q.inp == '0)
      else $error("clear did not zero registers");
   a_abort_keep: assert property ((ev.stop || ev.start) && !s_q.wr_done
      |=> $stable(s_q.inp) && $stable(s_q.dac))
      else $error("aborted write changed registers");
   a_repeat_read: assert property (s_q.st == ST_MACK && ev.scl_rise
      && !ev.sda && !ev.start && !ev.stop |=> s_q.st == ST_TXN)
      else $error("readback not repeated after master ack");
   a_exit_delay: assert property (s_q.pd != PD_NORMAL
      ##1 s_q.pd == PD_NORMAL |-> !out_amp_on [*8])
      else $error("amplifier back too early");
   a_pd_switch: assert property (s_q.pd != PD_NORMAL |-> !out_amp_on
      && out_gnd_1k == (s_q.pd == PD_GND_1K)
      && out_open == (s_q.pd == PD_OPEN))
      else $error("output stage not switched in power-down");

   c_write_commit: cover property (ev.stop && s_q.wr_done);
   c_repeat_read: cover property (s_q.st == ST_TXN ##[1:400] s_q.st == ST_TXB);
   c_pd_exit: cover property (s_q.rec == 6'h1);

endmodule

// >>> verification/qdac_twm.sv
/*
 * two-wire bus master model: start, stop and byte transfers on hclk.
 * assumes the bench builds the pulled-up sda wire from both drivers.
 */
`timescale 1ns/1ps
module qdac_twm (
   input wire logic hclk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   // bus idle high from time zero
   initial begin
      scl <= 1'b1;
      sda_low <= 1'b0;
   end

   // wait whole hclk cycles
   task automatic tk(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // one bit: low 6 cycles, high 2, sampled inside the high part
   task automatic bit_io(input logic b, output logic r);
      tk(5);
      sda_low <= ~b;
      tk(1);
      scl <= 1'b1;
      tk(1);
      r = sda;
      tk(1);
      scl <= 1'b0;
   endtask

   // start or repeated start
   // long first wait lets the slave drop its acknowledge
   task automatic start;
      tk(6);
      sda_low <= 1'b0;
      tk(2);
      scl <= 1'b1;
      tk(2);
      sda_low <= 1'b1;
      tk(2);
      scl <= 1'b0;
   endtask

   // stop, clock then stands high
   task automatic stop;
      tk(6);
      sda_low <= 1'b1;
      tk(2);
      scl <= 1'b1;
      tk(2);
      sda_low <= 1'b0;
      tk(4);
   endtask

   // msb first, ninth bit for acknowledge
   task automatic xfer(input logic [7:0] d, input logic m9,
      output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(m9, a);
   endtask
endmodule

// >>> verification/testbench.sv
/*
 * self-checking bench of the quad converter control block: serial
 * traffic through the master model and AHB-Lite register accesses.
 * assumes hclk at 20 MHz and a pulled-up sda wire.
 */
`timescale 1ns/1ps
module testbench;
   import qdac_pkg::*;
   localparam int CEIL = 40000;
   localparam logic [7:0] AW = {ADDR_HI, 2'h0};
   localparam logic [7:0] AR = {ADDR_HI, 2'h1};
   localparam logic [3:0] OUTS [4] = '{4'h0, 4'h4, 4'h2, 4'h1};
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans, md;
   logic scl, sda_low, sda_oe, sda_out, a0, amp, g1k, g100k, opn, ak;
   logic [3:0][11:0] dac_code;
   logic [1:0] pwrdn_mode;
   logic [7:0] q8;
   wire sda;
   int mismatches, n_tests, cyc;

   qdac_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_select_pin(a0), .dac_code(dac_code),
      .pwrdn_mode(pwrdn_mode), .out_amp_on(amp), .out_gnd_1k(g1k),
      .out_gnd_100k(g100k), .out_open(opn));
   qdac_twm m (.hclk(hclk), .sda(sda), .scl(scl), .sda_low(sda_low));
   // open-drain wire with pull-up
   assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;

   // clock and hang limit
   initial hclk = 1'b0;
   always #25 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc++;
      if (cyc == CEIL) begin
         mismatches++;
         close_out();
      end
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask

   // one AHB single transfer, read data taken in the data phase
   task automatic ahb(input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   // send a byte and compare the acknowledge (0 = taken)
   task automatic sb(input logic [7:0] d, input logic e);
      m.xfer(d, 1'b1, q8, ak);
      chk(32'(ak), 32'(e));
   endtask

   task automatic wr(input logic [7:0] p, input logic [15:0] w);
      m.start();
      sb(AW, 1'b0);
      sb(p, 1'b0);
      sb(w[15:8], 1'b0);
      sb(w[7:0], 1'b0);
      m.stop();
      m.tk(10);
   endtask

   // read n words, master acknowledges all but the last
   task automatic rd(input logic usep, input logic [7:0] p,
      input logic [15:0] e, input int n);
      logic [15:0] g;
      m.start();
      if (usep) begin
         sb(AW, 1'b0);
         sb(p, 1'b0);
         m.start();
      end
      sb(AR, 1'b0);
      for (int i = 0; i < n; i++) begin
         m.xfer(8'hFF, 1'b0, g[15:8], ak);
         m.xfer(8'hFF, i == n - 1, g[7:0], ak);
         chk(32'(g), 32'(e));
      end
      m.stop();
      m.tk(10);
   endtask

   // main sequence
   initial begin
      hresetn <= 1'b0;
      hsel <= 1'b0;
      haddr <= 32'h0;
      htrans <= 2'h0;
      hwrite <= 1'b0;
      hwdata <= 32'h0;
      a0 <= 1'b1;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      chk(32'({amp, g1k, g100k, opn, pwrdn_mode}), 32'h20);
      chk(32'(dac_code[1:0]), 32'h0);
      chk(32'(dac_code[3:2]), 32'h0);
      ahb(1'b0, 32'h10, 32'h0, q);
      chk(q, 32'h2);
      chk(32'(hresp), 32'h0);
      ahb(1'b1, 32'h18, 32'h5, q);
      ahb(1'b0, 32'h18, 32'h0, q);
      chk(q, 32'h0);
      $display("reset test done");
      m.start();
      sb(AW, 1'b1);
      m.stop();
      a0 <= 1'b0;
      ahb(1'b1, 32'h14, 32'h0, q);
      m.start();
      sb(AW, 1'b1);
      m.stop();
      ahb(1'b1, 32'h14, 32'h1, q);
      ahb(1'b0, 32'h14, 32'h0, q);
      chk(q, 32'h1);
      $display("address test done");
      wr(8'h01, 16'h3A5C);
      chk(32'(dac_code[0]), 32'h0);
      ahb(1'b0, 32'h10, 32'h0, q);
      chk(q, 32'h113);
      rd(1'b1, 8'h01, 16'h3A5C, 2);
      rd(1'b0, 8'h00, 16'h3A5C, 1);
      wr(8'h02, 16'h23F1);
      chk(32'(dac_code[1:0]), 32'h3F1A5C);
      ahb(1'b0, 32'h10, 32'h0, q);
      chk(q, 32'h202);
      wr(8'h0C, 16'h2777);
      chk(32'(dac_code[3:2]), 32'h777777);
      rd(1'b1, 8'h0C, RB_DEFAULT, 1);
      $display("load test done");
      for (int i = 1; i <= 4; i++) begin
         md = 2'(i);
         m.start();
         sb(AW, 1'b0);
         sb(8'h01, 1'b0);
         sb({md, 2'h3, 4'h0}, 1'b0);
         chk(32'(pwrdn_mode), 32'(md));
         chk(32'({amp, g1k, g100k, opn}), 32'(OUTS[md]));
         m.stop();
         m.tk(40);
         chk(32'(dac_code[0]), 32'hA5C);
      end
      chk(32'(amp), 32'h1);
      $display("power-down test done");
      wr(8'h01, 16'h0000);
      chk(32'(dac_code[1:0]), 32'h0);
      chk(32'(dac_code[3:2]), 32'h0);
      ahb(1'b0, 32'h0C, 32'h0, q);
      chk(q, 32'h0);
      $display("clear test done");
      close_out();
   end
endmodule
